// ===== logic/rca_core.sv
`timescale 1ns/1ps
// Functional notes
// - key1, key2, then set alias unlocks writes
// - ten-bit signed calibration applied every minute
// - negative removes pulses, positive adds pulses
// - seconds write restarts calibration, keeps value
// - four-bit interval mask in alarm bits 11:8
// - mask codes half-second up to yearly
// - flag raised one clock after match
// - one-shot alarm clears its own enable
// - eight-bit repeat count, 0xFF gives 256
// - decrement per alarm, last alarm at zero
// - chime wraps count and keeps enable
// - alarms only while enable bit 15 set
// - every alarm sets flag, software clears
// - toggling alarm pulse with initial level
// - time writes pass only with write enable
module rca_core
  import rca_pkg::*;
#(
  parameter int UNLOCK_WIN = UNLOCK_WIN_CYC
)
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic [31:0]      o_hrdata,
  output logic             o_hresp,
  input  wire logic        i_half_tick,
  input  wire logic        i_half_sec,
  input  wire logic        i_minute_tick,
  input  wire logic        i_sync_window,
  input  wire logic [31:0] i_time_digits,
  input  wire logic [31:0] i_date_digits,
  output logic             o_time_wr,
  output logic [31:0]      o_time_wdata,
  output logic             o_timer_on,
  output logic             o_cal_step,
  output logic             o_cal_add,
  output logic             o_alarm_event,
  output logic             o_alarm_irq_flag,
  output logic             o_alarm_pulse
);
  if (UNLOCK_WIN < 1 || UNLOCK_WIN >= (1 << UNL_CNT_W))
  begin
    $error("UNLOCK_WIN out of range");
  end

  typedef struct packed {
    logic                 hready;
    logic [31:0]          hrdata;
    logic                 pend;
    logic                 a_wr;
    logic [7:0]           a_addr;
    rca_unl_t             ustate;
    logic [UNL_CNT_W-1:0] ucnt;
    logic                 wren;
    logic                 on;
    logic [CAL_W-1:0]     cal;
    logic                 aen;
    logic                 chime;
    logic                 pulse_initial_level;
    logic [MASK_W-1:0]    alarm_interval_mask;
    logic [RPT_W-1:0]     alarm_repeat_count;
    logic [31:0]          atime;
    logic [31:0]          adate;
    logic                 match_d;
    logic                 event_q;
    logic                 irq;
    logic                 pulse;
    logic                 time_wr;
    logic [31:0]          twdata;
  } rca_st_t;

  rca_st_t st_reg;
  rca_st_t st_next;
  logic    match;
  logic    wr_now;

  // ----------------------------------------------------------------
  // digit selection per interval mask
  // ----------------------------------------------------------------
  function automatic logic [63:0] rca_digit_mask(input logic [MASK_W-1:0] m);
    case (m)
      4'h2:    rca_digit_mask = {TM_SEC1, RST_WORD};
      4'h3:    rca_digit_mask = {TM_SEC, RST_WORD};
      4'h4:    rca_digit_mask = {TM_MIN1, RST_WORD};
      4'h5:    rca_digit_mask = {TM_MIN, RST_WORD};
      4'h6:    rca_digit_mask = {TM_HOUR, RST_WORD};
      4'h7:    rca_digit_mask = {TM_HOUR, DM_WDAY};
      4'h8:    rca_digit_mask = {TM_HOUR, DM_DAY};
      4'h9:    rca_digit_mask = {TM_HOUR, DM_MONTH};
      default: rca_digit_mask = {RST_WORD, RST_WORD};
    endcase
  endfunction

  // mask codes, reserved codes never match
  // digits from selected one down to seconds
  always_comb
  begin
    logic [63:0] dm;
    dm    = rca_digit_mask(st_reg.alarm_interval_mask);
    match = (st_reg.alarm_interval_mask <= MASK_LAST)
         && ((i_time_digits & dm[63:32]) == (st_reg.atime & dm[63:32]))
         && ((i_date_digits & dm[31:0]) == (st_reg.adate & dm[31:0]))
         && ((st_reg.alarm_interval_mask == '0) || !i_half_sec);
  end

  assign wr_now = st_reg.pend && st_reg.a_wr;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next         = st_reg;
    st_next.time_wr = 1'b0;
    st_next.event_q = 1'b0;
    // zero-wait address phase, one wait state in data phase
    if (st_reg.pend)
    begin
      st_next.pend   = 1'b0;
      st_next.hready = 1'b1;
      case (st_reg.a_addr)
        OFS_CTRL:   st_next.hrdata = {16'h0000, st_reg.on, 11'h000, st_reg.wren,
                                      i_sync_window, 2'b00};
        OFS_CAL:    st_next.hrdata = {22'h000000, st_reg.cal};
        OFS_ALARM:  st_next.hrdata = {16'h0000, st_reg.aen, st_reg.chime, st_reg.pulse_initial_level,
                                      i_sync_window & st_reg.aen, st_reg.alarm_interval_mask, st_reg.alarm_repeat_count};
        OFS_TIME:   st_next.hrdata = i_time_digits;
        OFS_ATIME:  st_next.hrdata = st_reg.atime;
        OFS_ADATE:  st_next.hrdata = st_reg.adate;
        OFS_STATUS: st_next.hrdata = {31'h00000000, st_reg.irq};
        default:    st_next.hrdata = RST_WORD;
      endcase
    end
    else if (i_hsel && i_htrans[1] && i_hready)
    begin
      st_next.pend   = 1'b1;
      st_next.hready = 1'b0;
      st_next.a_wr   = i_hwrite;
      st_next.a_addr = i_haddr[7:0];
    end

    if (st_reg.ustate == UNL_KEY2)
    begin
      st_next.ucnt = UNL_CNT_W'(st_reg.ucnt - 1'b1);
      if (st_reg.ucnt == '0)
      begin
        st_next.ustate = UNL_IDLE;
      end
    end

    if (wr_now)
    begin
      // any write breaks the key sequence
      st_next.ustate = UNL_IDLE;
      case (st_reg.a_addr)
        OFS_KEY:
        begin
          if (i_hwdata == UNLOCK_KEY1)
          begin
            st_next.ustate = UNL_KEY1;
          end
          else if (st_reg.ustate == UNL_KEY1 && i_hwdata == UNLOCK_KEY2)
          begin
            st_next.ustate = UNL_KEY2;
            st_next.ucnt   = UNL_CNT_W'(UNLOCK_WIN);
          end
        end
        OFS_CTRL:
        begin
          st_next.on   = i_hwdata[CTRL_ON_BIT];
          st_next.wren = st_reg.wren & i_hwdata[CTRL_WREN_BIT];
        end
        OFS_CTRL_SET:
        begin
          st_next.on = st_reg.on | i_hwdata[CTRL_ON_BIT];
          // enable set only right after both keys
          if (st_reg.ustate == UNL_KEY2 && i_hwdata[CTRL_WREN_BIT])
          begin
            st_next.wren = 1'b1;
          end
        end
        OFS_CTRL_CLR:
        begin
          st_next.on   = st_reg.on & ~i_hwdata[CTRL_ON_BIT];
          st_next.wren = st_reg.wren & ~i_hwdata[CTRL_WREN_BIT];
        end
        OFS_CAL:    st_next.cal = i_hwdata[CAL_W-1:0];
        OFS_ALARM:
        begin
          st_next.aen   = i_hwdata[AL_EN_BIT];
          st_next.chime = i_hwdata[AL_CHIME_BIT];
          st_next.pulse_initial_level   = i_hwdata[AL_PIV_BIT];
          st_next.alarm_interval_mask = i_hwdata[AL_MASK_LSB +: MASK_W];
          st_next.alarm_repeat_count  = i_hwdata[RPT_W-1:0];
        end
        OFS_TIME:
        begin
          // time write forwarded only when enabled
          st_next.time_wr = st_reg.wren;
          st_next.twdata  = i_hwdata;
        end
        OFS_ATIME:  st_next.atime = i_hwdata;
        OFS_ADATE:  st_next.adate = i_hwdata;
        OFS_STATUS: st_next.irq   = st_reg.irq & ~i_hwdata[0];
        default:    st_next.wren  = st_reg.wren;
      endcase
    end

    // sample compare on each half-second tick
    st_next.match_d = i_half_tick && st_reg.aen && st_reg.on && match;

    // event one clock after the match
    if (st_reg.match_d && st_reg.aen)
    begin
      st_next.event_q = 1'b1;
      // flag set regardless of mask, set beats clear
      st_next.irq     = 1'b1;
      st_next.pulse   = ~st_reg.pulse;
      if (st_reg.alarm_repeat_count == RPT_ZERO && !st_reg.chime)
      begin
        // one-shot or last repeat turns alarm off
        st_next.aen = 1'b0;
      end
      else
      begin
        // count down; chime wraps to 0xFF
        st_next.alarm_repeat_count = RPT_W'(st_reg.alarm_repeat_count - 1'b1);
      end
    end
    // idle level, also taken by the enabling write
    if (!st_next.aen || !st_reg.aen)
    begin
      st_next.pulse = st_next.pulse_initial_level;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st_reg        <= '0;
      st_reg.hready <= 1'b1;
      st_reg.ustate <= UNL_IDLE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // calibration sequencer
  // ----------------------------------------------------------------
  // a forwarded time write restarts the sequence
  rca_cal_seq u_cal (
    .i_sys_clk     (i_sys_clk),
    .i_resetn      (i_resetn),
    .i_minute_tick (i_minute_tick),
    .i_restart     (st_reg.time_wr),
    .i_on          (st_reg.on),
    .i_cal         (st_reg.cal),
    .o_step        (o_cal_step),
    .o_add         (o_cal_add)
  );

  assign o_hreadyout      = st_reg.hready;
  assign o_hrdata         = st_reg.hrdata;
  assign o_hresp          = 1'b0;
  assign o_time_wr        = st_reg.time_wr;
  assign o_time_wdata     = st_reg.twdata;
  assign o_timer_on       = st_reg.on;
  assign o_alarm_event    = st_reg.event_q;
  assign o_alarm_irq_flag = st_reg.irq;
  assign o_alarm_pulse    = st_reg.pulse;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_unlock_seq: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    $rose(st_reg.wren) |-> $past(st_reg.ustate) == UNL_KEY2
      && $past(st_reg.a_addr) == OFS_CTRL_SET && $past(wr_now))
    else $error("write enable set without unlock");
  a_alarm_delay: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_half_tick && st_reg.aen && st_reg.on && match && !wr_now) |=> ##1 o_alarm_event)
    else $error("alarm event not one clock after match");
  a_flag_sets: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_alarm_event |-> o_alarm_irq_flag)
    else $error("alarm flag not set on event");
  a_oneshot_off: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (st_reg.match_d && st_reg.aen && st_reg.alarm_repeat_count == 8'h00 && !st_reg.chime) |=> !st_reg.aen)
    else $error("one-shot alarm stayed enabled");
  a_repeat_dec: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (st_reg.match_d && st_reg.aen && st_reg.alarm_repeat_count != 8'h00 && !wr_now)
      |=> st_reg.alarm_repeat_count == $past(st_reg.alarm_repeat_count) - 8'h01 && st_reg.aen)
    else $error("repeat count not decremented");
  a_chime_wrap: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (st_reg.match_d && st_reg.aen && st_reg.chime && st_reg.alarm_repeat_count == 8'h00 && !wr_now)
      |=> st_reg.alarm_repeat_count == 8'hFF && st_reg.aen)
    else $error("chime did not wrap");
  a_enable_gate: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_alarm_event |-> $past(st_reg.aen, 1) && $past(st_reg.aen, 2))
    else $error("alarm while disabled");
  a_pulse_idle: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    !st_reg.aen |-> o_alarm_pulse == st_reg.pulse_initial_level)
    else $error("alarm pulse not at initial level");
  a_pulse_toggle: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (o_alarm_event && st_reg.aen) |-> o_alarm_pulse != $past(o_alarm_pulse))
    else $error("alarm pulse missed toggle");
  a_time_gate: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_time_wr |-> $past(st_reg.wren))
    else $error("time write without write enable");
  a_bus_wait: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_hsel && i_htrans[1] && o_hreadyout && !st_reg.pend) |=> !o_hreadyout ##1 o_hreadyout)
    else $error("bus answer timing broken");

  c_unlock: cover property (@(posedge i_sys_clk) disable iff (!i_resetn) $rose(st_reg.wren));
  c_oneshot: cover property (@(posedge i_sys_clk) disable iff (!i_resetn) $fell(st_reg.aen)
    && o_alarm_event);
  c_chime: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_alarm_event && st_reg.chime && st_reg.alarm_repeat_count == 8'hFF);
  c_time_wr: cover property (@(posedge i_sys_clk) disable iff (!i_resetn) o_time_wr);
endmodule

// ===== logic/rca_pkg.sv
package rca_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_CTRL_SET  = 8'h04;
  localparam logic [7:0] OFS_CTRL_CLR  = 8'h08;
  localparam logic [7:0] OFS_CAL       = 8'h0C;
  localparam logic [7:0] OFS_ALARM     = 8'h10;
  localparam logic [7:0] OFS_TIME      = 8'h20;
  localparam logic [7:0] OFS_ATIME     = 8'h30;
  localparam logic [7:0] OFS_ADATE     = 8'h40;
  localparam logic [7:0] OFS_STATUS    = 8'h50;
  localparam logic [7:0] OFS_KEY       = 8'h60;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_ON_BIT   = 15;
  localparam int CTRL_WREN_BIT = 3;
  localparam int CTRL_SYNC_BIT = 2;
  localparam int AL_EN_BIT     = 15;
  localparam int AL_CHIME_BIT  = 14;
  localparam int AL_PIV_BIT    = 13;
  localparam int AL_SYNC_BIT   = 12;
  localparam int AL_MASK_LSB   = 8;
  localparam int CAL_W         = 10;
  localparam int MASK_W        = 4;
  localparam int RPT_W         = 8;
  // ----------------------------------------------------------------
  // keys, reset values, digit masks
  // ----------------------------------------------------------------
  localparam logic [31:0] UNLOCK_KEY1  = 32'hAA996655;
  localparam logic [31:0] UNLOCK_KEY2  = 32'h556699AA;
  localparam logic [31:0] RST_WORD     = 32'h00000000;
  localparam logic [RPT_W-1:0] RPT_MAX = 8'hFF;
  localparam logic [RPT_W-1:0] RPT_ZERO = 8'h00;
  localparam logic [MASK_W-1:0] MASK_LAST = 4'h9;
  localparam logic [31:0] TM_SEC1  = 32'h00000F00;
  localparam logic [31:0] TM_SEC   = 32'h0000FF00;
  localparam logic [31:0] TM_MIN1  = 32'h000FFF00;
  localparam logic [31:0] TM_MIN   = 32'h00FFFF00;
  localparam logic [31:0] TM_HOUR  = 32'hFFFFFF00;
  localparam logic [31:0] DM_WDAY  = 32'h000000FF;
  localparam logic [31:0] DM_DAY   = 32'h0000FF00;
  localparam logic [31:0] DM_MONTH = 32'h00FFFF00;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int UNLOCK_WIN_CYC = 2;
  localparam int UNL_CNT_W      = 4;
  // ----------------------------------------------------------------
  // unlock sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    UNL_IDLE = 3'b001,
    UNL_KEY1 = 3'b010,
    UNL_KEY2 = 3'b100
  } rca_unl_t;
endpackage

// ===== logic/rca_cal_seq.sv
`timescale 1ns/1ps
module rca_cal_seq
  import rca_pkg::*;
(
  input  wire logic             i_sys_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_minute_tick,
  input  wire logic             i_restart,
  input  wire logic             i_on,
  input  wire logic [CAL_W-1:0] i_cal,
  output logic                  o_step,
  output logic                  o_add
);
  typedef struct packed {
    logic [CAL_W-1:0] left;
    logic             add;
    logic             step;
  } rca_cs_t;

  rca_cs_t cs_reg;
  rca_cs_t cs_next;

  function automatic logic [CAL_W-1:0] rca_abs(input logic [CAL_W-1:0] v);
    rca_abs = v[CAL_W-1] ? CAL_W'(~v + 1'b1) : v;
  endfunction

  always_comb
  begin
    cs_next      = cs_reg;
    cs_next.step = 1'b0;
    if (i_restart)
    begin
      cs_next.left = '0;
    end
    else if (i_minute_tick && i_on && (i_cal != '0))
    begin
      cs_next.left = rca_abs(i_cal);
      cs_next.add  = ~i_cal[CAL_W-1];
    end
    else if (cs_reg.left != '0)
    begin
      cs_next.step = 1'b1;
      cs_next.left = CAL_W'(cs_reg.left - 1'b1);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cs_reg <= '0;
    end
    else
    begin
      cs_reg <= cs_next;
    end
  end

  assign o_step = cs_reg.step;
  assign o_add  = cs_reg.add;

  a_cal_restart: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_restart |=> !o_step ##1 (cs_reg.left == '0 || $past(i_minute_tick)))
    else $error("calibration continued after seconds write");
  a_cal_load: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (!i_restart && i_minute_tick && i_on && i_cal == 10'h3FD) |=> !o_step ##1
    (o_step && !o_add) [*3] ##1 !o_step)
    else $error("wrong step count for minus three");
  c_cal_step: cover property (@(posedge i_sys_clk) disable iff (!i_resetn) o_step && o_add);
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb
  import rca_pkg::*;
;
  logic        clk    = 1'h0;
  logic        rstn   = 1'h0;
  logic        hsel   = 1'h0;
  logic        hwrite = 1'h0;
  logic        htk    = 1'h0;
  logic        hs     = 1'h0;
  logic        mt     = 1'h0;
  logic        sw     = 1'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize  = 3'h2;
  logic [31:0] haddr  = '0;
  logic [31:0] hwdata = '0;
  logic [31:0] td     = '0;
  logic [31:0] dd     = '0;
  logic [31:0] rd;
  logic [31:0] qd;
  logic [31:0] q[$];
  logic        lastadd;
  wire         hrdy, hresp, twr, ton, cst, cadd, aev, aflag, apul;
  wire  [31:0] hrdata, twd;
  int bad_count = 0, num_checks = 0, cyc = 0, ev = 0, st = 0, tw = 0;
  // reference model of the alarm engine
  int m_en = 0, m_ch = 0, m_piv = 0, m_mask = 0, m_rpt = 0, m_flag = 0, m_pul = 0, m_evt = 0;

  rca_core u_rca_core (
    .i_sys_clk(clk), .i_resetn(rstn), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hreadyout(hrdy), .o_hrdata(hrdata), .o_hresp(hresp), .i_half_tick(htk),
    .i_half_sec(hs), .i_minute_tick(mt), .i_sync_window(sw), .i_time_digits(td),
    .i_date_digits(dd), .o_time_wr(twr), .o_time_wdata(twd), .o_timer_on(ton),
    .o_cal_step(cst), .o_cal_add(cadd), .o_alarm_event(aev), .o_alarm_irq_flag(aflag),
    .o_alarm_pulse(apul)
  );

  always #50 clk = ~clk;

  // ----------------------------------------------------------------
  // monitors and run limit
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      bad_count++;
      finish_test();
    end
    if (aev === 1'h1) ev++;
    if (cst === 1'h1)
    begin
      st++;
      lastadd = cadd;
    end
    if (twr === 1'h1)
    begin
      tw++;
      qd = (q.size() > 0) ? q.pop_front() : 32'hDEADBEEF;
      `CHK("time wdata", qd, twd)
    end
  end

  task automatic finish_test();
    if (bad_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // bus master, entered right after a rising edge
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h000000, a};
    do @(posedge clk); while (hrdy !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'h1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, '0);
    `CHK($sformatf("reg %0h", a), e, rd)
  endtask

  function automatic logic [31:0] actl();
    return {16'h0000, m_en[0], m_ch[0], m_piv[0], 1'h0, m_mask[3:0], m_rpt[7:0]};
  endfunction

  task automatic setal(input int en, input int ch, input int pulse_initial_level, input int mk, input int rp);
    if (m_en == 0) m_pul = pulse_initial_level;
    m_en = en; m_ch = ch; m_piv = pulse_initial_level; m_mask = mk; m_rpt = rp;
    wr(OFS_ALARM, actl());
  endtask

  // one half-second tick; ok says whether the compare should match (digits under the mask, half-second phase, reserved codes)
  task automatic fire(input int ok);
    htk <= 1'h1;
    @(posedge clk);
    htk <= 1'h0;
    repeat (4) @(posedge clk);
    if (m_en != 0 && ok != 0)
    begin
      m_evt++; m_flag = 1; m_pul = 1 - m_pul;
      if (m_rpt == 0 && m_ch == 0) m_en = 0;
      else m_rpt = (m_rpt + 255) % 256;
    end
    if (m_en == 0) m_pul = m_piv;
    `CHK("events", m_evt, ev)
    `CHK("irq flag", m_flag[0], aflag)
    `CHK("pulse", m_pul[0], apul)
    rdc(OFS_ALARM, actl());
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  logic [7:0]  ra[8] = '{OFS_CTRL, OFS_CAL, OFS_ALARM, OFS_ATIME, OFS_ADATE, OFS_STATUS,
                         OFS_KEY, 8'h70};
  logic [31:0] k1[4] = '{UNLOCK_KEY1, UNLOCK_KEY2, UNLOCK_KEY1, UNLOCK_KEY1};
  logic [31:0] k2[4] = '{UNLOCK_KEY2, UNLOCK_KEY1, UNLOCK_KEY2, UNLOCK_KEY1};
  int          gp[4] = '{0, 0, 12, 0};
  int          ue[4] = '{1, 0, 0, 0};
  logic [9:0]  cv[4] = '{10'h3FD, 10'h200, 10'h1FF, 10'h001};
  int          tm[8] = '{6, 5, 7, 6, 2, 1, 1, 10};
  logic [31:0] tx[8] = '{32'h01000000, 32'h01000000, '0, '0, 32'h00000100, 32'h00000100,
                         '0, '0};
  logic [31:0] dx[8] = '{'0, '0, 32'h00000001, 32'h00000001, '0, '0, '0, '0};
  logic        hh[8] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0};
  int          te[8] = '{0, 1, 0, 1, 0, 1, 0, 0};

  initial
  begin
    logic [31:0] tv, dv, d;
    int mag, e0;
    void'($urandom(62));
    repeat (20) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    foreach (ra[i]) rdc(ra[i], '0);
    `CHK("hresp", 1'h0, hresp)
    wr(OFS_TIME, 32'h12345600);
    wr(OFS_CTRL_SET, 32'h00000008);
    `CHK("blocked writes", 0, tw)
    rdc(OFS_CTRL, '0);
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_KEY, k1[i]);
      wr(OFS_KEY, k2[i]);
      repeat (gp[i]) @(posedge clk);
      wr(OFS_CTRL_SET, 32'h00000008);
      rdc(OFS_CTRL, ue[i] << 3);
      wr(OFS_CTRL, '0);
    end
    wr(OFS_KEY, UNLOCK_KEY1);
    wr(OFS_KEY, UNLOCK_KEY2);
    wr(OFS_CTRL_SET, 32'h00008008);
    sw <= 1'h1;
    rdc(OFS_CTRL, 32'h0000800C);
    `CHK("timer on", 1'h1, ton)
    sw <= 1'h0;
    repeat (3)
    begin
      d = $urandom;
      q.push_back(d);
      wr(OFS_TIME, d);
    end
    @(posedge clk);
    `CHK("time writes", 3, tw)
    // calibration bursts, extremes and one random value
    cv[3] = 10'($urandom_range(1023, 1));
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_CAL, {22'h000000, cv[i]});
      rdc(OFS_CAL, {22'h000000, cv[i]});
      st = 0;
      mt <= 1'h1;
      @(posedge clk);
      mt <= 1'h0;
      repeat (520) @(posedge clk);
      mag = cv[i][9] ? 1024 - int'(cv[i]) : int'(cv[i]);
      `CHK("cal steps", mag, st)
      `CHK("cal dir", ~cv[i][9], lastadd)
    end
    // a time write mid-burst aborts it but keeps the value
    wr(OFS_CAL, 32'h00000064);
    st = 0;
    mt <= 1'h1;
    @(posedge clk);
    mt <= 1'h0;
    repeat (20) @(posedge clk);
    d = $urandom;
    q.push_back(d);
    wr(OFS_TIME, d);
    repeat (120) @(posedge clk);
    `CHK("aborted burst", 1'h1, st < 100)
    rdc(OFS_CAL, 32'h00000064);
    st = 0;
    mt <= 1'h1;
    @(posedge clk);
    mt <= 1'h0;
    repeat (120) @(posedge clk);
    `CHK("cal steps", 100, st)
    // alarm engine
    tv = $urandom;
    dv = $urandom;
    td <= tv;
    dd <= dv;
    wr(OFS_ATIME, tv);
    wr(OFS_ADATE, dv);
    rdc(OFS_ATIME, tv);
    rdc(OFS_ADATE, dv);
    setal(0, 0, 1, 0, 0);
    setal(1, 0, 1, 0, 255);
    e0 = ev;
    repeat (257) fire(1);
    `CHK("alarm total", 256, ev - e0)
    wr(OFS_STATUS, 32'h00000001);
    m_flag = 0;
    rdc(OFS_STATUS, '0);
    `CHK("irq flag", 1'h0, aflag)
    setal(1, 1, 1, 0, 1);
    for (int m = 0; m < 10; m++)
    begin
      setal(1, 1, 1, m, m_rpt);
      fire(1);
    end
    for (int i = 0; i < 8; i++)
    begin
      setal(1, 1, 1, tm[i], m_rpt);
      td <= tv ^ tx[i];
      dd <= dv ^ dx[i];
      hs <= hh[i];
      fire(te[i]);
      td <= tv;
      dd <= dv;
      hs <= 1'h0;
    end
    setal(0, 1, 1, 0, m_rpt);
    fire(1);
    // enabling write brings a new initial level
    setal(1, 1, 0, 0, 3);
    fire(1);
    // clear alias drops write enable, time writes blocked again
    wr(OFS_CTRL_CLR, 32'h00000008);
    rdc(OFS_CTRL, 32'h00008000);
    wr(OFS_TIME, 32'h00000000);
    @(posedge clk);
    `CHK("blocked writes", 4, tw)
    finish_test();
  end
endmodule
